// ===== common/cgc_defs.vh
// register offsets, field positions, reset values and codes of the clock generator control block
// assumes a byte wide register port with one cycle read latency
`ifndef CGC_DEFS_VH
`define CGC_DEFS_VH
// register offsets (chosen)
`define CGC_OFF_CTL_ONE   3'h0
`define CGC_OFF_CTL_TWO   3'h1
`define CGC_OFF_STATUS    3'h2
`define CGC_OFF_DIVCFG    3'h3
// control one fields
`define CGC_GAIN_BIT      7
`define CGC_RANGE_BIT     6
`define CGC_RSRC_BIT      5
`define CGC_MODE_HI       4
`define CGC_MODE_LO       3
`define CGC_KEEP_BIT      2
`define CGC_LDOF_BIT      1
// control two fields
`define CGC_LKRE_BIT      7
`define CGC_MULT_HI       6
`define CGC_MULT_LO       4
`define CGC_CKRE_BIT      3
`define CGC_DIV_HI        2
`define CGC_DIV_LO        0
// status fields
`define CGC_ST_MODE_HI    7
`define CGC_ST_MODE_LO    6
`define CGC_ST_REF_BIT    5
`define CGC_ST_LOL_BIT    4
`define CGC_ST_LOC_BIT    2
`define CGC_ST_EXTV_BIT   1
`define CGC_ST_BUSY_BIT   0
// reset values
`define CGC_RST_CTL_ONE   8'h00
`define CGC_RST_CTL_TWO   8'h00
`define CGC_RST_DIVCFG    8'h02
// clock mode codes
`define CGC_MODE_SLF      2'h0
`define CGC_MODE_EIN      2'h1
`define CGC_MODE_BYP      2'h2
`define CGC_MODE_ENG      2'h3
// prescale factors
`define CGC_PRESCALE_LOW  7'h40
`define CGC_PRESCALE_HIGH 7'h01
// default cycles a field update takes to complete
`define CGC_SYNC_CYCLES   8'h04
`endif

// ===== hw/cgc_clock_gen_ctrl.v
// control register layer of the clock generator: two control registers, status and decoded outputs
// assumes a synchronous byte register port and status inputs already in the ref_clk domain
//
// Operation
// - gain bit selects low power or high gain, once
// - write-once bits take only first write after reset
// - range 0 gives prescale 64, 1 gives 1
// - range write-once, acts only in external modes
// - reference select write-once, 0 clock, 1 crystal
// - mode field bits 4:3, 00 self, 01 internal
// - mode 10 bypass external, 11 engaged external
// - bypass external waits until reference is valid
// - reference valid flag mirrors stable reference clock
// - off mode leaves stored mode field unchanged
// - mode write dropped while earlier one pending
// - first write 0X blocks later 1X writes
// - oscillator keep-in-off enable per mode and gain
// - loss-of-clock disable bit turns detection off
// - lock loss response acts only while sticky set
// - lock loss flag sticky until software clears
// - multiplication field bits 6:4 sets factor N
// - multiplier write dropped while earlier one pending
// - loss-of-clock response: interrupt 0, reset 1
// - divide field bits 2:0 gives power of two
// - divider write dropped while earlier one pending
//
// The register offsets and the plain strobed port were decided locally.
`include "cgc_defs.vh"

module cgc_clock_gen_ctrl #(
    parameter [7:0] SYNC_CYCLES = `CGC_SYNC_CYCLES  // cycles for a field update to cross over
) (
    input  wire        ref_clk,
    input  wire        resetn,
    input  wire [2:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    input  wire        ext_ref_valid,
    input  wire        ref_kind_status,
    input  wire        lock_lost_evt,
    input  wire        clock_lost_evt,
    input  wire        off_mode,
    output reg  [1:0]  clock_mode_status,
    output reg  [1:0]  clock_mode_sel,
    output reg         osc_high_gain_sel,
    output reg         range_high,
    output reg         ext_ref_source_sel,
    output reg         osc_enable,
    output reg         clock_loss_detect_off,
    output reg  [2:0]  fll_mult_sel,
    output reg  [4:0]  fll_mult_factor,
    output reg  [2:0]  post_div_sel,
    output reg  [7:0]  post_div_factor,
    output reg  [6:0]  prescale_factor,
    output reg  [15:0] eng_ratio_num,
    output wire        ext_pin_used,
    output wire        lock_loss_irq,
    output wire        lock_loss_rst,
    output wire        clock_loss_irq,
    output wire        clock_loss_rst,
    output reg         lock_loss_sticky,
    output reg         clock_loss_sticky
);

    // pending-update states, one-hot
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_BUSY = 2'b10;

    // multiplication code to factor
    function [4:0] mult_of;
        input [2:0] code;
        begin
            case (code)
                3'h0:    mult_of = 5'h04;
                3'h1:    mult_of = 5'h06;
                3'h2:    mult_of = 5'h08;
                3'h3:    mult_of = 5'h0a;
                3'h4:    mult_of = 5'h0c;
                3'h5:    mult_of = 5'h0e;
                3'h6:    mult_of = 5'h12;
                default: mult_of = 5'h12; // code 7 treated as 6
            endcase
        end
    endfunction

    // update-pending counter step shared by three fields
    function [7:0] cnt_next;
        input [7:0] cnt;
        begin
            cnt_next = (cnt == 8'h00) ? 8'h00 : cnt - 8'h01;
        end
    endfunction

    reg        gain_q;          // gain select
    reg        range_q;         // frequency range
    reg        rsrc_q;          // reference source
    reg [1:0]  mode_req_q;      // stored mode field
    reg [1:0]  mode_act_q;      // mode actually in use
    reg        keep_q;          // oscillator keep in off
    reg        ldof_q;          // loss of clock detection off
    reg        once_done_q;     // first control one write seen
    reg        ext_pin_q;       // external pin reserved by first write
    reg        lkre_q;          // lock loss response select
    reg        ckre_q;          // clock loss response select
    reg [2:0]  mult_q;          // multiplication code
    reg [2:0]  div_q;           // divider code
    reg [1:0]  mode_st_q;       // mode update state
    reg [7:0]  mode_cnt_q;      // mode update remaining
    reg [1:0]  mult_st_q;       // multiplier update state
    reg [7:0]  mult_cnt_q;      // multiplier update remaining
    reg [1:0]  div_st_q;        // divider update state
    reg [7:0]  div_cnt_q;       // divider update remaining
    reg [1:0]  mode_pend_q;     // mode awaiting completion
    reg [2:0]  mult_pend_q;     // multiplier awaiting completion
    reg [2:0]  div_pend_q;      // divider awaiting completion

    wire wr_one = reg_wr && (reg_addr == `CGC_OFF_CTL_ONE);  // control one write
    wire wr_two = reg_wr && (reg_addr == `CGC_OFF_CTL_TWO);  // control two write
    wire wr_st  = reg_wr && (reg_addr == `CGC_OFF_STATUS);   // status write clears
    wire [1:0] new_mode = reg_wdata[`CGC_MODE_HI:`CGC_MODE_LO];
    wire mode_busy = mode_st_q[1];
    wire mult_busy = mult_st_q[1];
    wire div_busy  = div_st_q[1];
    // mode write allowed: none pending and external code permitted
    wire mode_ok = !mode_busy && !(once_done_q && !ext_pin_q && new_mode[1]);

    // control one register with write-once bits
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            gain_q      <= 1'b0;
            range_q     <= 1'b0;
            rsrc_q      <= 1'b0;
            keep_q      <= 1'b0;
            ldof_q      <= 1'b0;
            once_done_q <= 1'b0;
            ext_pin_q   <= 1'b0;
        end else if (wr_one) begin
            keep_q <= reg_wdata[`CGC_KEEP_BIT];
            ldof_q <= reg_wdata[`CGC_LDOF_BIT];
            if (!once_done_q) begin                       // later writes ignored
                once_done_q <= 1'b1;
                gain_q      <= reg_wdata[`CGC_GAIN_BIT];
                range_q     <= reg_wdata[`CGC_RANGE_BIT];
                rsrc_q      <= reg_wdata[`CGC_RSRC_BIT];
                ext_pin_q   <= new_mode[1];
            end
        end
    end

    // mode field: store, then count down to completion
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mode_req_q  <= `CGC_MODE_SLF;
            mode_pend_q <= `CGC_MODE_SLF;
            mode_st_q   <= ST_IDLE;
            mode_cnt_q  <= 8'h00;
        end else begin
            case (mode_st_q)
                ST_IDLE: begin
                    if (wr_one && mode_ok) begin
                        mode_req_q  <= new_mode;          // off mode never touches this
                        mode_pend_q <= new_mode;
                        mode_st_q   <= ST_BUSY;
                        mode_cnt_q  <= SYNC_CYCLES;
                    end
                end
                ST_BUSY: begin
                    mode_cnt_q <= cnt_next(mode_cnt_q);
                    if (mode_cnt_q == 8'h00)
                        mode_st_q <= ST_IDLE;
                end
                default: mode_st_q <= ST_IDLE;
            endcase
        end
    end

    // mode in use follows the request; bypass waits for valid reference
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mode_act_q <= `CGC_MODE_SLF;
        end else if (!mode_busy && !off_mode && mode_act_q != mode_pend_q) begin
            if (mode_pend_q != `CGC_MODE_BYP || ext_ref_valid)
                mode_act_q <= mode_pend_q;
        end
    end

    // control two: response bits and pending multiplier and divider
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            lkre_q      <= 1'b0;
            ckre_q      <= 1'b0;
            mult_pend_q <= 3'h0;
            div_pend_q  <= 3'h0;
            mult_st_q   <= ST_IDLE;
            div_st_q    <= ST_IDLE;
            mult_cnt_q  <= 8'h00;
            div_cnt_q   <= 8'h00;
        end else begin
            if (wr_two) begin
                lkre_q <= reg_wdata[`CGC_LKRE_BIT];
                ckre_q <= reg_wdata[`CGC_CKRE_BIT];
            end
            case (mult_st_q)
                ST_IDLE: begin
                    if (wr_two) begin                     // dropped when busy
                        mult_pend_q <= reg_wdata[`CGC_MULT_HI:`CGC_MULT_LO];
                        mult_st_q   <= ST_BUSY;
                        mult_cnt_q  <= SYNC_CYCLES;
                    end
                end
                ST_BUSY: begin
                    mult_cnt_q <= cnt_next(mult_cnt_q);
                    if (mult_cnt_q == 8'h00)
                        mult_st_q <= ST_IDLE;
                end
                default: mult_st_q <= ST_IDLE;
            endcase
            case (div_st_q)
                ST_IDLE: begin
                    if (wr_two) begin                     // dropped when busy
                        div_pend_q <= reg_wdata[`CGC_DIV_HI:`CGC_DIV_LO];
                        div_st_q   <= ST_BUSY;
                        div_cnt_q  <= SYNC_CYCLES;
                    end
                end
                ST_BUSY: begin
                    div_cnt_q <= cnt_next(div_cnt_q);
                    if (div_cnt_q == 8'h00)
                        div_st_q <= ST_IDLE;
                end
                default: div_st_q <= ST_IDLE;
            endcase
        end
    end

    // completed multiplier and divider codes
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mult_q <= 3'h0;
            div_q  <= 3'h0;
        end else begin
            if (mult_busy && mult_cnt_q == 8'h00)
                mult_q <= mult_pend_q;
            if (div_busy && div_cnt_q == 8'h00)
                div_q <= div_pend_q;
        end
    end

    // sticky loss flags; set wins over a clear in the same cycle
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            lock_loss_sticky  <= 1'b0;
            clock_loss_sticky <= 1'b0;
        end else begin
            if (lock_lost_evt)
                lock_loss_sticky <= 1'b1;
            else if (wr_st && reg_wdata[`CGC_ST_LOL_BIT])
                lock_loss_sticky <= 1'b0;
            if (clock_lost_evt && !ldof_q)
                clock_loss_sticky <= 1'b1;                // detection gated
            else if (wr_st && reg_wdata[`CGC_ST_LOC_BIT])
                clock_loss_sticky <= 1'b0;
        end
    end

    // requests only while the sticky flag stands
    assign lock_loss_irq  = lock_loss_sticky && !lkre_q;
    assign lock_loss_rst  = lock_loss_sticky && lkre_q;
    assign clock_loss_irq = clock_loss_sticky && !ckre_q;
    assign clock_loss_rst = clock_loss_sticky && ckre_q;
    assign ext_pin_used   = ext_pin_q;

    // decoded control outputs
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            clock_mode_status     <= `CGC_MODE_SLF;
            clock_mode_sel        <= `CGC_MODE_SLF;
            osc_high_gain_sel     <= 1'b0;
            range_high            <= 1'b0;
            ext_ref_source_sel    <= 1'b0;
            osc_enable            <= 1'b0;
            clock_loss_detect_off <= 1'b0;
            fll_mult_sel          <= 3'h0;
            fll_mult_factor       <= 5'h04;
            post_div_sel          <= 3'h0;
            post_div_factor       <= 8'h01;
            prescale_factor       <= `CGC_PRESCALE_HIGH;
            eng_ratio_num         <= 16'h0000;
        end else begin
            clock_mode_status     <= mode_act_q;
            clock_mode_sel        <= mode_act_q;
            osc_high_gain_sel     <= gain_q;
            ext_ref_source_sel    <= rsrc_q;
            clock_loss_detect_off <= ldof_q;
            fll_mult_sel          <= mult_q;
            fll_mult_factor       <= mult_of(mult_q);
            post_div_sel          <= div_q;
            post_div_factor       <= 8'h01 << div_q;
            // range only matters with an external mode
            if (mode_act_q[1]) begin
                range_high      <= range_q;
                prescale_factor <= range_q ? `CGC_PRESCALE_HIGH : `CGC_PRESCALE_LOW;
            end else begin
                range_high      <= 1'b0;
                prescale_factor <= `CGC_PRESCALE_HIGH;
            end
            // output/ref ratio numerator P*N; divide by post_div_factor
            if (mode_act_q == `CGC_MODE_ENG)
                eng_ratio_num <= {9'h000, prescale_factor} * {11'h000, fll_mult_factor};
            else
                eng_ratio_num <= 16'h0000;
            // oscillator enable: external modes when running, or off mode per keep bit unless gain and range are both set
            if (!mode_act_q[1])
                osc_enable <= 1'b0;
            else if (!off_mode)
                osc_enable <= 1'b1;
            else if (gain_q && range_q)
                osc_enable <= 1'b1;                                          // keep bit ignored
            else if (keep_q)
                osc_enable <= ref_kind_status;
            else
                osc_enable <= ref_kind_status && (mode_req_q == `CGC_MODE_BYP);
        end
    end

    // read data one cycle after the read strobe
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `CGC_OFF_CTL_ONE: reg_rdata <= {gain_q, range_q, rsrc_q, mode_req_q, keep_q, ldof_q, 1'b0};
                `CGC_OFF_CTL_TWO: reg_rdata <= {lkre_q, mult_q, ckre_q, div_q};
                `CGC_OFF_STATUS:  reg_rdata <= {mode_act_q, ref_kind_status, lock_loss_sticky, 1'b0,
                                                clock_loss_sticky, ext_ref_valid,
                                                mode_busy | mult_busy | div_busy};
                default:          reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule // cgc_clock_gen_ctrl

// ===== tb/cgc_ext_src_model.sv
// far side model: external clock or crystal source feeding the reference status inputs
// assumes the bench switches it on and picks the source kind by level at clock edges
module cgc_ext_src_model #(
    parameter int STARTUP = 6  // cycles the source needs before it counts as stable
) (
    input  logic ref_clk,
    input  logic resetn,
    input  logic src_on,
    input  logic src_xtal,
    output logic ext_ref_valid,
    output logic ref_kind_status
);
    logic [7:0] warm_q;  // start-up counter, restarts whenever the source stops

    // count up to the start-up span while the source runs
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            warm_q <= 8'h00;
        end else if (!src_on) begin
            warm_q <= 8'h00;
        end else if (warm_q != 8'(STARTUP)) begin
            warm_q <= warm_q + 8'h01;
        end
    end
    // valid only once stable, low again as soon as the source stops
    assign ext_ref_valid = src_on && (warm_q == 8'(STARTUP));
    // crystal kind reported only while the source runs
    assign ref_kind_status = src_on && src_xtal;
endmodule  // cgc_ext_src_model

// ===== tb/cgc_clock_gen_ctrl_sva.sv
// checker of the clock generator control block, watching its ports only
// assumes a single clock domain with an asynchronous active low reset
module cgc_clock_gen_ctrl_sva (
    input logic       ref_clk,
    input logic       resetn,
    input logic       ext_ref_valid,
    input logic       lock_lost_evt,
    input logic       clock_lost_evt,
    input logic [1:0] clock_mode_sel,
    input logic       range_high,
    input logic       clock_loss_detect_off,
    input logic [2:0] fll_mult_sel,
    input logic [4:0] fll_mult_factor,
    input logic [2:0] post_div_sel,
    input logic [7:0] post_div_factor,
    input logic [6:0] prescale_factor,
    input logic       ext_pin_used,
    input logic       lock_loss_irq,
    input logic       lock_loss_rst,
    input logic       lock_loss_sticky,
    input logic       clock_loss_sticky
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    property p_mult_map; fll_mult_factor == ((fll_mult_sel > 3'h5) ? 5'h12 : 5'h04 + {1'b0, fll_mult_sel, 1'b0}); endproperty
    a_mult_map: assert property (p_mult_map) else $error("bad multiplier factor");
    property p_div_map; post_div_factor == (8'h01 << post_div_sel); endproperty
    a_div_map: assert property (p_div_map) else $error("bad divider factor");
    property p_prescale; prescale_factor == ((clock_mode_sel[1] && !range_high) ? 7'h40 : 7'h01); endproperty
    a_prescale: assert property (p_prescale) else $error("prescale factor wrong");
    property p_range_ext; range_high |-> clock_mode_sel[1]; endproperty
    a_range_ext: assert property (p_range_ext) else $error("range acts outside external modes");
    property p_pin_block; !ext_pin_used |-> !clock_mode_sel[1]; endproperty
    a_pin_block: assert property (p_pin_block) else $error("external mode without reserved pin");
    property p_bypass_wait; (clock_mode_sel == 2'h2) && !$stable(clock_mode_sel) |-> $past(ext_ref_valid); endproperty
    a_bypass_wait: assert property (p_bypass_wait) else $error("bypass too early");
    property p_lock_set; lock_lost_evt |=> lock_loss_sticky; endproperty
    a_lock_set: assert property (p_lock_set) else $error("lock loss not latched");
    property p_lock_resp; lock_loss_sticky == (lock_loss_irq ^ lock_loss_rst) && !(lock_loss_irq && lock_loss_rst); endproperty
    a_lock_resp: assert property (p_lock_resp) else $error("lock loss request wrong");
    property p_clock_off; clock_loss_detect_off && !clock_loss_sticky |=> !clock_loss_sticky; endproperty
    a_clock_off: assert property (p_clock_off) else $error("loss seen, detection off");
    property p_clock_set; clock_lost_evt && !clock_loss_detect_off |=> clock_loss_sticky; endproperty
    a_clock_set: assert property (p_clock_set) else $error("clock loss not latched");

    // main scenarios reached
    c_bypass: cover property (clock_mode_sel == 2'h2);
    c_lock_rst: cover property (lock_loss_rst);
    c_low_range: cover property (prescale_factor == 7'h40);
endmodule  // cgc_clock_gen_ctrl_sva

bind cgc_clock_gen_ctrl cgc_clock_gen_ctrl_sva cgc_clock_gen_ctrl_sva_i (.*);

// ===== tb/cgc_clock_gen_ctrl_bench.sv
// self-checking bench of the clock generator control block, one task per scenario
// assumes the checker is bound to the design and the source model drives the reference status
module cgc_clock_gen_ctrl_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int SYNC    = 2;         // shortened field update crossing
    localparam int STARTUP = 6;         // source start-up span
    localparam int W       = SYNC + 6;  // covers a whole field update up to the outputs
    logic       ref_clk, resetn, reg_wr, reg_rd, lock_lost_evt, clock_lost_evt, off_mode, src_on, src_xtal;
    logic [2:0] reg_addr, fll_mult_sel, post_div_sel;
    logic [7:0] reg_wdata, reg_rdata, post_div_factor;
    logic [1:0] clock_mode_sel;
    logic [4:0] fll_mult_factor;
    logic [6:0] prescale_factor;
    logic [15:0] eng_ratio_num;
    logic       osc_high_gain_sel, range_high, osc_enable, clock_loss_detect_off, ext_pin_used, ext_ref_valid;
    logic       lock_loss_irq, lock_loss_rst, clock_loss_irq, clock_loss_rst, lock_loss_sticky, clock_loss_sticky;
    logic       ref_kind_status;
    integer     n_errors = 0;
    integer     check_count = 0;

    cgc_clock_gen_ctrl #(.SYNC_CYCLES(8'(SYNC))) cgc_clock_gen_ctrl_i (
        .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_ref_valid(ext_ref_valid), .ref_kind_status(ref_kind_status),
        .lock_lost_evt(lock_lost_evt), .clock_lost_evt(clock_lost_evt), .off_mode(off_mode),
        .clock_mode_status(), .clock_mode_sel(clock_mode_sel), .osc_high_gain_sel(osc_high_gain_sel),
        .range_high(range_high), .ext_ref_source_sel(), .osc_enable(osc_enable),
        .clock_loss_detect_off(clock_loss_detect_off), .fll_mult_sel(fll_mult_sel), .fll_mult_factor(fll_mult_factor),
        .post_div_sel(post_div_sel), .post_div_factor(post_div_factor), .prescale_factor(prescale_factor),
        .eng_ratio_num(eng_ratio_num), .ext_pin_used(ext_pin_used), .lock_loss_irq(lock_loss_irq),
        .lock_loss_rst(lock_loss_rst), .clock_loss_irq(clock_loss_irq), .clock_loss_rst(clock_loss_rst),
        .lock_loss_sticky(lock_loss_sticky), .clock_loss_sticky(clock_loss_sticky));
    cgc_ext_src_model #(.STARTUP(STARTUP)) cgc_ext_src_model_i (
        .ref_clk(ref_clk), .resetn(resetn), .src_on(src_on), .src_xtal(src_xtal),
        .ext_ref_valid(ext_ref_valid), .ref_kind_status(ref_kind_status));

    // 250 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // compare and count
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // verdict and end of run
    task complete_run();
        if (n_errors == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // wait n edges, then step off the edge to sample
    task settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // one-cycle register write
    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // two writes to one address with no gap
    task wr2(input logic [2:0] a, input logic [7:0] d1, input logic [7:0] d2);
        @(posedge ref_clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d1;
        @(posedge ref_clk);
        reg_wdata <= d2;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // read, data looked at in the cycle after the strobe
    task rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    // one-cycle loss event, lock loss or clock loss
    task pulse(input bit lock);
        @(posedge ref_clk);
        if (lock) lock_lost_evt <= 1'b1;
        else clock_lost_evt <= 1'b1;
        @(posedge ref_clk);
        lock_lost_evt <= 1'b0; clock_lost_evt <= 1'b0;
        #1;
    endtask
    // reset held 5 cycles, source off
    task do_reset();
        @(posedge ref_clk);
        resetn <= 1'b0; src_on <= 1'b0; src_xtal <= 1'b0; off_mode <= 1'b0;
        repeat (5) @(posedge ref_clk);
        resetn <= 1'b1;
    endtask

    // reset values and an unmapped address
    task t_defaults();
        rd(3'h0, 8'h00);
        rd(3'h1, 8'h00);
        rd(3'h2, 8'h00);
        rd(3'h5, 8'h00);
        chk(fll_mult_factor, 4);
        chk(post_div_factor, 1);
    endtask
    // write-once bits and a mode write while busy
    task t_once();
        do_reset();
        wr(3'h0, 8'hf8);
        settle(W);
        rd(3'h0, 8'hf8);
        chk(osc_high_gain_sel, 1);
        chk(range_high, 1);
        chk(prescale_factor, 1);
        wr(3'h0, 8'h08);
        settle(W);
        rd(3'h0, 8'he8);
        chk(range_high, 0);
        chk(clock_mode_sel, 1);
        wr2(3'h0, 8'h00, 8'h18);
        settle(W);
        rd(3'h0, 8'he0);
        chk(clock_mode_sel, 0);
    endtask
    // low range gives prescale 64 in engaged external mode
    task t_range();
        do_reset();
        wr(3'h0, 8'h18);
        settle(W);
        chk(prescale_factor, 7'h40);
        chk(clock_mode_sel, 3);
        chk(eng_ratio_num, 16'h0100);
        wr(3'h0, 8'h58);
        settle(W);
        chk(prescale_factor, 7'h40);
    endtask
    // first write internal blocks external codes
    task t_pin();
        do_reset();
        wr(3'h0, 8'h08);
        settle(W);
        wr(3'h0, 8'h18);
        settle(W);
        rd(3'h0, 8'h08);
        chk(ext_pin_used, 0);
        wr(3'h0, 8'h00);
        settle(W);
        rd(3'h0, 8'h00);
    endtask
    // bypass waits for a valid reference, off mode keeps the field
    task t_bypass();
        do_reset();
        wr(3'h0, 8'h10);
        settle(W);
        chk(clock_mode_sel, 0);
        @(posedge ref_clk);
        src_on <= 1'b1;
        settle(STARTUP + W);
        chk(clock_mode_sel, 2);
        rd(3'h2, 8'h82);
        @(posedge ref_clk);
        off_mode <= 1'b1;
        settle(4);
        rd(3'h0, 8'h10);
        @(posedge ref_clk);
        off_mode <= 1'b0;
    endtask
    // oscillator in off mode follows the keep bit
    task t_keep();
        do_reset();
        src_on <= 1'b1; src_xtal <= 1'b1;
        wr(3'h0, 8'h38);
        settle(STARTUP + W);
        @(posedge ref_clk);
        off_mode <= 1'b1;
        settle(4);
        chk(osc_enable, 0);
        wr(3'h0, 8'h3c);
        settle(W);
        chk(osc_enable, 1);
        @(posedge ref_clk);
        off_mode <= 1'b0;
    endtask
    // every multiplier and divider code, then a write dropped while busy
    task t_factors();
        do_reset();
        for (int i = 0; i < 8; i++) begin
            wr(3'h1, {1'b0, 3'(i), 1'b0, 3'(i)});
            settle(W);
            chk(fll_mult_factor, 16'((i > 5) ? 18 : 4 + 2 * i));
            chk(post_div_factor, 16'(1 << i));
        end
        wr2(3'h1, 8'h11, 8'h22);
        settle(W);
        chk(fll_mult_sel, 1);
        chk(post_div_sel, 1);
    endtask
    // loss of lock and loss of clock requests
    task t_loss();
        do_reset();
        pulse(1'b1);
        chk(lock_loss_sticky, 1);
        chk(lock_loss_irq, 1);
        wr(3'h1, 8'h80);
        settle(1);
        chk(lock_loss_rst, 1);
        wr(3'h2, 8'h10);
        settle(1);
        chk(lock_loss_rst, 0);
        wr(3'h0, 8'h02);
        settle(W);
        pulse(1'b0);
        chk(clock_loss_sticky, 0);
        wr(3'h0, 8'h00);
        settle(W);
        pulse(1'b0);
        chk(clock_loss_irq, 1);
        wr(3'h1, 8'h08);
        settle(1);
        chk(clock_loss_rst, 1);
    endtask

    // main sequence
    initial begin
        resetn = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 3'h0; reg_wdata = 8'h00;
        lock_lost_evt = 1'b0; clock_lost_evt = 1'b0; off_mode = 1'b0; src_on = 1'b0; src_xtal = 1'b0;
        do_reset();
        t_defaults();
        t_once();
        t_range();
        t_pin();
        t_bypass();
        t_keep();
        t_factors();
        t_loss();
        complete_run();
    end
    // watchdog, far beyond the expected few hundred cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        complete_run();
    end
endmodule  // cgc_clock_gen_ctrl_bench
